// [logic/dcrf_pkg.sv]
package dcrf_pkg;

    // Register byte addresses on APB
    localparam logic [11:0] DCRF_OFS_ACC0_W = 12'h000;
    localparam logic [11:0] DCRF_OFS_ACC0_X = 12'h004;
    localparam logic [11:0] DCRF_OFS_ACC1_W = 12'h008;
    localparam logic [11:0] DCRF_OFS_ACC1_X = 12'h00c;
    localparam logic [11:0] DCRF_OFS_DATA = 12'h020;
    localparam logic [11:0] DCRF_OFS_PTR = 12'h040;
    localparam logic [11:0] DCRF_OFS_LOOP = 12'h060;
    localparam logic [11:0] DCRF_OFS_DAG = 12'h080;
    localparam logic [11:0] DCRF_OFS_STAT = 12'h0c0;
    localparam logic [11:0] DCRF_OFS_SPCMD = 12'h0c4;

    // Pointer file positions
    localparam logic [2:0] DCRF_PTR_SP = 3'h6;
    localparam logic [2:0] DCRF_PTR_FP = 3'h7;

    // Reset values
    localparam logic [31:0] DCRF_RST_WORD = 32'h0000_0000;
    localparam logic [39:0] DCRF_RST_ACC = 40'h00_0000_0000;

    // Saturation limits of the 40-bit accumulators
    localparam logic [39:0] DCRF_ACC_MAX = 40'h7f_ffff_ffff;
    localparam logic [39:0] DCRF_ACC_MIN = 40'h80_0000_0000;

    // Stack push step in bytes
    localparam logic [31:0] DCRF_PUSH_STEP = 32'h0000_0004;

    // Views of one register, or of an odd-even register pair, for a core write
    typedef enum logic [2:0] {
        DCRF_VIEW_WORD = 3'b000,
        DCRF_VIEW_LOW = 3'b001,
        DCRF_VIEW_HIGH = 3'b010,
        DCRF_VIEW_EXT = 3'b011,
        DCRF_VIEW_WORDZ = 3'b100,
        DCRF_VIEW_FULL = 3'b101,
        DCRF_VIEW_PAIR = 3'b110
    } dcrf_view_t;

    // Core write request for data registers and accumulators
    typedef struct packed {
        logic valid;
        logic is_acc;
        logic [2:0] index;
        dcrf_view_t view;
        logic [63:0] data;
    } dcrf_wreq_t;

endpackage

// [logic/dcrf_core.sv]
// Chosen here: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Each accumulator is reached as a 32-bit low word, two 16-bit halves and an 8-bit extension above bit 31.
// - Only wide core results written into an accumulator are saturated to 40 bits; view and APB writes are not.
// - The eight data registers are written as whole words or as independent low and high halves.
// - Pair operations use only odd-even pairs with the odd register as the upper word.
// - Pointer registers, stack and frame pointer included, are 32 bits and written only whole.
// - The stack pointer holds the last occupied byte and a push decrements it.
// - The frame pointer is a 32-bit member of the pointer set.
// - Two loop register sets each hold a top address, an iteration count and a bottom address.
// - Four 32-bit index registers hold byte addresses for indirect addressing.
// - Four modify, four length and four base registers accompany the index registers.
// - A saturated value is the largest magnitude of the same sign as the true result.
// - Saturation never sets the overflow flag.
module dcrf_core
    import dcrf_pkg::*;
(
    input wire logic I_CLK_SYS,
    input wire logic I_RESET,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire dcrf_wreq_t i_core_wr,
    input wire logic i_acc_wide_wr,
    input wire logic i_acc_wide_sel,
    input wire logic [40:0] i_acc_wide,
    input wire logic i_push,
    output logic [39:0] o_acc0,
    output logic [39:0] o_acc1,
    output logic o_sat_seen
);

    logic [39:0] acc_r [2];
    logic [31:0] data_r [8];
    logic [31:0] ptr_r [8];
    logic [31:0] loop_r [6];
    logic [31:0] dag_r [16];
    logic sat_seen_r;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    logic [39:0] sat_nxt;
    logic sat_hit;

    wire apb_set = i_psel && !i_penable;
    wire apb_wr = i_psel && i_penable && pready_r && i_pwrite;
    wire [11:0] a = i_paddr;

    always_comb begin
        sat_hit = 1'b0;
        sat_nxt = i_acc_wide[39:0];
        if (i_acc_wide[40] != i_acc_wide[39]) begin
            sat_hit = 1'b1;
            sat_nxt = i_acc_wide[40] ? DCRF_ACC_MIN : DCRF_ACC_MAX;
        end
    end

    // Accumulators: wide core results, view writes, APB words
    generate
        for (genvar g = 0; g < 2; g++) begin : g_acc
            always_ff @(posedge I_CLK_SYS) begin
                if (I_RESET) begin
                    acc_r[g] <= DCRF_RST_ACC;
                end else if (i_acc_wide_wr && i_acc_wide_sel == 1'(g)) begin
                    acc_r[g] <= sat_nxt;
                end else if (i_core_wr.valid && i_core_wr.is_acc && i_core_wr.index[0] == 1'(g)) begin
                    case (i_core_wr.view)
                        DCRF_VIEW_WORD: acc_r[g] <= {{8{i_core_wr.data[31]}}, i_core_wr.data[31:0]};
                        DCRF_VIEW_WORDZ: acc_r[g] <= {8'h00, i_core_wr.data[31:0]};
                        DCRF_VIEW_LOW: acc_r[g][15:0] <= i_core_wr.data[15:0];
                        DCRF_VIEW_HIGH: acc_r[g][31:16] <= i_core_wr.data[15:0];
                        DCRF_VIEW_EXT: acc_r[g][39:32] <= i_core_wr.data[7:0];
                        DCRF_VIEW_FULL: acc_r[g] <= i_core_wr.data[39:0];
                        default: acc_r[g] <= acc_r[g];
                    endcase
                end else if (apb_wr && a == (1'(g) ? DCRF_OFS_ACC1_W : DCRF_OFS_ACC0_W)) begin
                    acc_r[g] <= {{8{i_pwdata[31]}}, i_pwdata};
                end else if (apb_wr && a == (1'(g) ? DCRF_OFS_ACC1_X : DCRF_OFS_ACC0_X)) begin
                    acc_r[g][39:32] <= i_pwdata[7:0];
                end
            end
        end
    endgenerate

    // Data registers: words, halves and odd-even pairs
    generate
        for (genvar d = 0; d < 8; d++) begin : g_data
            wire hit = i_core_wr.valid && !i_core_wr.is_acc;
            always_ff @(posedge I_CLK_SYS) begin
                if (I_RESET) begin
                    data_r[d] <= DCRF_RST_WORD;
                end else if (hit && i_core_wr.view == DCRF_VIEW_PAIR && i_core_wr.index[2:1] == 2'(d >> 1)) begin
                    data_r[d] <= 1'(d) ? i_core_wr.data[63:32] : i_core_wr.data[31:0];
                end else if (hit && i_core_wr.index == 3'(d)) begin
                    case (i_core_wr.view)
                        DCRF_VIEW_WORD: data_r[d] <= i_core_wr.data[31:0];
                        DCRF_VIEW_LOW: data_r[d][15:0] <= i_core_wr.data[15:0];
                        DCRF_VIEW_HIGH: data_r[d][31:16] <= i_core_wr.data[15:0];
                        default: data_r[d] <= data_r[d];
                    endcase
                end else if (apb_wr && a == DCRF_OFS_DATA + 12'(d * 4)) begin
                    data_r[d] <= i_pwdata;
                end
            end
        end
    endgenerate

    // Pointer set, stack pointer at slot 6 and frame pointer at slot 7
    generate
        for (genvar p = 0; p < 8; p++) begin : g_ptr
            always_ff @(posedge I_CLK_SYS) begin
                if (I_RESET) begin
                    ptr_r[p] <= DCRF_RST_WORD;
                end else if (i_push && 3'(p) == DCRF_PTR_SP) begin
                    ptr_r[p] <= ptr_r[p] - DCRF_PUSH_STEP;
                end else if (apb_wr && a == DCRF_OFS_PTR + 12'(p * 4)) begin
                    ptr_r[p] <= i_pwdata;
                end
            end
        end
    endgenerate

    // Loop sets: top, count, bottom per set
    generate
        for (genvar l = 0; l < 6; l++) begin : g_loop
            always_ff @(posedge I_CLK_SYS) begin
                if (I_RESET) begin
                    loop_r[l] <= DCRF_RST_WORD;
                end else if (apb_wr && a == DCRF_OFS_LOOP + 12'(l * 4)) begin
                    loop_r[l] <= i_pwdata;
                end
            end
        end
    endgenerate

    // Index, modify, length, base: four of each
    generate
        for (genvar k = 0; k < 16; k++) begin : g_dag
            always_ff @(posedge I_CLK_SYS) begin
                if (I_RESET) begin
                    dag_r[k] <= DCRF_RST_WORD;
                end else if (apb_wr && a == DCRF_OFS_DAG + 12'(k * 4)) begin
                    dag_r[k] <= i_pwdata;
                end
            end
        end
    endgenerate

    // Sticky saturation status; no overflow flag is raised here
    // no overflow flag
    always_ff @(posedge I_CLK_SYS) begin
        if (I_RESET) begin
            sat_seen_r <= 1'b0;
        end else if (i_acc_wide_wr && sat_hit) begin
            sat_seen_r <= 1'b1;
        end else if (apb_wr && a == DCRF_OFS_STAT && i_pwdata[0]) begin
            sat_seen_r <= 1'b0;
        end
    end

    // APB read mux, registered in the setup cycle so no wait state is needed
    always_ff @(posedge I_CLK_SYS) begin
        if (I_RESET) begin
            prdata_r <= 32'h0000_0000;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end else if (apb_set) begin
            pready_r <= 1'b1;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
            if (a[1:0] != 2'h0) begin
                pslverr_r <= 1'b1;
            end else if (a == DCRF_OFS_ACC0_W) begin
                prdata_r <= acc_r[0][31:0];
            end else if (a == DCRF_OFS_ACC0_X) begin
                prdata_r <= {24'h000000, acc_r[0][39:32]};
            end else if (a == DCRF_OFS_ACC1_W) begin
                prdata_r <= acc_r[1][31:0];
            end else if (a == DCRF_OFS_ACC1_X) begin
                prdata_r <= {24'h000000, acc_r[1][39:32]};
            end else if (a >= DCRF_OFS_DATA && a < DCRF_OFS_PTR) begin
                prdata_r <= data_r[a[4:2]];
            end else if (a >= DCRF_OFS_PTR && a < DCRF_OFS_LOOP) begin
                prdata_r <= ptr_r[a[4:2]];
            end else if (a >= DCRF_OFS_LOOP && a < DCRF_OFS_LOOP + 12'h018) begin
                prdata_r <= loop_r[3'(a[4:2])];
            end else if (a >= DCRF_OFS_DAG && a < DCRF_OFS_STAT) begin
                prdata_r <= dag_r[a[5:2]];
            end else if (a == DCRF_OFS_STAT) begin
                prdata_r <= {31'h00000000, sat_seen_r};
            end else begin
                pslverr_r <= 1'b1;
            end
        end else begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end
    end

    // Accumulator mirrors for the execution units
    always_ff @(posedge I_CLK_SYS) begin
        if (I_RESET) begin
            o_acc0 <= DCRF_RST_ACC;
            o_acc1 <= DCRF_RST_ACC;
        end else begin
            o_acc0 <= acc_r[0];
            o_acc1 <= acc_r[1];
        end
    end

    assign o_prdata = prdata_r;
    assign o_pready = pready_r;
    assign o_pslverr = pslverr_r;
    assign o_sat_seen = sat_seen_r;

    // Saturated value follows the true sign
    chk_sat_sign: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET)
        (i_acc_wide_wr && !i_acc_wide_sel && sat_hit) |=> acc_r[0][39] == $past(i_acc_wide[40]))
        else $error("saturated sign wrong");

    // In-range results stored unchanged
    chk_sat_pass: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET)
        (i_acc_wide_wr && i_acc_wide_sel && !sat_hit) |=> acc_r[1] == $past(i_acc_wide[39:0]))
        else $error("in-range result altered");

    // Half writes to data register 2, the one the core side exercises
    sequence s_low_wr2;
        i_core_wr.valid && !i_core_wr.is_acc && i_core_wr.view == DCRF_VIEW_LOW && i_core_wr.index == 3'h2;
    endsequence

    sequence s_high_wr2;
        i_core_wr.valid && !i_core_wr.is_acc && i_core_wr.view == DCRF_VIEW_HIGH && i_core_wr.index == 3'h2;
    endsequence

    // Low half write keeps high half
    chk_half_keep: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET)
        s_low_wr2 |=> data_r[2][31:16] == $past(data_r[2][31:16]) && data_r[2][15:0] == $past(i_core_wr.data[15:0]))
        else $error("half write disturbed other half");

    // High half write keeps low half
    chk_high_keep: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET)
        s_high_wr2 |=> data_r[2][15:0] == $past(data_r[2][15:0]) && data_r[2][31:16] == $past(i_core_wr.data[15:0]))
        else $error("high half write disturbed low half");

    // Whole word APB write to the last data register
    chk_data_word: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET)
        (apb_wr && a == DCRF_OFS_DATA + 12'h01c && !i_core_wr.valid) |=> data_r[7] == $past(i_pwdata))
        else $error("data word not written");

    // Frame pointer slot takes the full word
    chk_fp_word: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET)
        (apb_wr && a == DCRF_OFS_PTR + 12'h01c) |=> ptr_r[7] == $past(i_pwdata))
        else $error("frame pointer not written");

    // Stack pointer slot takes the full word when no push competes
    chk_sp_word: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET)
        (apb_wr && a == DCRF_OFS_PTR + 12'h018 && !i_push) |=> ptr_r[6] == $past(i_pwdata))
        else $error("stack pointer not written");

    // First index register written over APB
    chk_index_wr: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET)
        (apb_wr && a == DCRF_OFS_DAG) |=> dag_r[0] == $past(i_pwdata))
        else $error("index register not written");

    // First length register written over APB
    chk_len_wr: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET)
        (apb_wr && a == DCRF_OFS_DAG + 12'h020) |=> dag_r[8] == $past(i_pwdata))
        else $error("length register not written");

    // Saturation only raises the sticky status
    chk_sat_sticky: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET)
        (i_acc_wide_wr && sat_hit) |=> sat_seen_r)
        else $error("saturation status not set");

    // Word view write sign-extends
    chk_word_ext: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET)
        (i_core_wr.valid && i_core_wr.is_acc && !i_core_wr.index[0] && i_core_wr.view == DCRF_VIEW_WORD
         && !i_acc_wide_wr) |=> acc_r[0][39:32] == {8{$past(i_core_wr.data[31])}})
        else $error("word view extension wrong");

    // Pair lands in odd-even registers
    chk_pair_split: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET)
        (i_core_wr.valid && !i_core_wr.is_acc && i_core_wr.view == DCRF_VIEW_PAIR && i_core_wr.index[2:1] == 2'h2)
        |=> data_r[5] == $past(i_core_wr.data[63:32]) && data_r[4] == $past(i_core_wr.data[31:0]))
        else $error("pair write misplaced");

    // Push moves stack pointer down by one word
    chk_push_dec: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET)
        i_push |=> ptr_r[6] == $past(ptr_r[6]) - DCRF_PUSH_STEP)
        else $error("stack pointer not decremented");

    // Extension view read shows bits above 31
    chk_ext_read: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET)
        (apb_set && a == DCRF_OFS_ACC1_X) |=> o_prdata == {24'h000000, $past(acc_r[1][39:32])} && o_pready)
        else $error("extension read wrong");

    // Loop count register takes the word written over APB
    chk_loop_wr: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET)
        (apb_wr && a == DCRF_OFS_LOOP + 12'h004) |=> loop_r[1] == $past(i_pwdata))
        else $error("loop count not written");

endmodule
`default_nettype wire

// [testbench/dcrf_core_model.sv]
`timescale 1ns/1ps
`default_nettype none
module dcrf_core_model
    import dcrf_pkg::*;
(
    input wire logic i_clk,
    output logic [$bits(dcrf_wreq_t)-1:0] o_core_wr,
    output logic o_acc_wide_wr,
    output logic o_acc_wide_sel,
    output logic [40:0] o_acc_wide,
    output logic o_push
);
    // Quiet pipeline until the bench asks for a write
    initial begin
        o_core_wr = '0;
        o_acc_wide_wr = 1'b0;
        o_acc_wide_sel = 1'b0;
        o_acc_wide = '0;
        o_push = 1'b0;
    end

    // One-cycle view write; fields other than view are scrambled after the pulse so stale data cannot pass
    task automatic view_wr(input logic is_acc, input logic [2:0] idx, input dcrf_view_t view,
        input logic [63:0] data);
        dcrf_wreq_t req;
        req = '{valid: 1'b1, is_acc: is_acc, index: idx, view: view, data: data};
        @(posedge i_clk);
        o_core_wr <= req;
        @(posedge i_clk);
        req = '{valid: 1'b0, is_acc: ~is_acc, index: ~idx, view: view, data: ~data};
        o_core_wr <= req;
    endtask

    // One-cycle wide result from the multiply-accumulate side
    task automatic wide_wr(input logic sel, input logic [40:0] val);
        @(posedge i_clk);
        o_acc_wide_wr <= 1'b1;
        o_acc_wide_sel <= sel;
        o_acc_wide <= val;
        @(posedge i_clk);
        o_acc_wide_wr <= 1'b0;
        o_acc_wide_sel <= ~sel;
        o_acc_wide <= ~val;
    endtask

    // One push pulse
    task automatic push_one();
        @(posedge i_clk);
        o_push <= 1'b1;
        @(posedge i_clk);
        o_push <= 1'b0;
    endtask
endmodule
`default_nettype wire

// [testbench/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench
    import dcrf_pkg::*;
;
    logic clk, rst, psel, penable, pwrite, pready, pslverr, awr, asel, push, sat;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [39:0] acc0, acc1;
    logic [40:0] awide;
    logic [$bits(dcrf_wreq_t)-1:0] cwr;
    logic rerr;
    int err_count, checks;

    dcrf_core dut (.I_CLK_SYS(clk), .I_RESET(rst), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
        .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_core_wr(cwr), .i_acc_wide_wr(awr), .i_acc_wide_sel(asel), .i_acc_wide(awide), .i_push(push),
        .o_acc0(acc0), .o_acc1(acc1), .o_sat_seen(sat));
    dcrf_core_model core (.i_clk(clk), .o_core_wr(cwr), .o_acc_wide_wr(awr), .o_acc_wide_sel(asel),
        .o_acc_wide(awide), .o_push(push));

    // Free-running system clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic stop_test();
        $display("counts: %0d checks, %0d mismatches", checks, err_count);
        if (err_count == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string msg);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    // APB transfer; request held until pready is seen at a rising edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) chk(0, 1, "pready timeout");
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic exp_err);
        apb(1'b0, a, 32'h0000_0000);
        chk(rdat, exp, "read data");
        chk(rerr, exp_err, "slave error");
    endtask

    // Let the accumulator copy settle, then compare
    task automatic acc_chk(input logic sel, input logic [39:0] exp);
        repeat (2) @(posedge clk);
        #1;
        chk(sel ? acc1 : acc0, exp, "accumulator");
    endtask

    // Tests
    initial begin
        rst = 1'b1;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd_chk(DCRF_OFS_ACC0_W, 32'h0000_0000, 1'b0);
        rd_chk(DCRF_OFS_STAT, 32'h0000_0000, 1'b0);
        for (int a = 32; a < 192; a += 4) begin
            if (a == 'h78 || a == 'h7c) begin
                rd_chk(12'(a), 32'h0000_0000, 1'b1);
            end else begin
                rd_chk(12'(a), DCRF_RST_WORD, 1'b0);
                apb(1'b1, 12'(a), {20'ha5c3e, 12'(a)});
                rd_chk(12'(a), {20'ha5c3e, 12'(a)}, 1'b0);
            end
        end
        $display("test register map done");
        apb(1'b1, 12'h022, 32'hdead_beef);
        chk(rerr, 1'b1, "misaligned write");
        rd_chk(12'h020, 32'ha5c3_e020, 1'b0);
        rd_chk(12'h100, 32'h0000_0000, 1'b1);
        $display("test refused access done");
        core.view_wr(1'b0, 3'h2, DCRF_VIEW_LOW, 64'h1234);
        rd_chk(12'h028, 32'ha5c3_1234, 1'b0);
        core.view_wr(1'b0, 3'h2, DCRF_VIEW_HIGH, 64'hbeef);
        rd_chk(12'h028, 32'hbeef_1234, 1'b0);
        core.view_wr(1'b0, 3'h5, DCRF_VIEW_PAIR, 64'h0123_4567_89ab_cdef);
        rd_chk(12'h034, 32'h0123_4567, 1'b0);
        rd_chk(12'h030, 32'h89ab_cdef, 1'b0);
        rd_chk(12'h02c, 32'ha5c3_e02c, 1'b0);
        $display("test data halves and pairs done");
        core.view_wr(1'b1, 3'h0, DCRF_VIEW_WORD, 64'h8000_0000);
        acc_chk(1'b0, 40'hff_8000_0000);
        core.view_wr(1'b1, 3'h0, DCRF_VIEW_WORDZ, 64'h8000_0000);
        acc_chk(1'b0, 40'h00_8000_0000);
        core.view_wr(1'b1, 3'h0, DCRF_VIEW_EXT, 64'h5c);
        acc_chk(1'b0, 40'h5c_8000_0000);
        core.view_wr(1'b1, 3'h0, DCRF_VIEW_LOW, 64'h1111);
        core.view_wr(1'b1, 3'h0, DCRF_VIEW_HIGH, 64'h2222);
        acc_chk(1'b0, 40'h5c_2222_1111);
        rd_chk(DCRF_OFS_ACC0_X, 32'h0000_005c, 1'b0);
        rd_chk(DCRF_OFS_ACC0_W, 32'h2222_1111, 1'b0);
        core.view_wr(1'b1, 3'h1, DCRF_VIEW_FULL, 64'h12_3456_789a);
        acc_chk(1'b1, 40'h12_3456_789a);
        apb(1'b1, DCRF_OFS_ACC1_W, 32'hffff_0000);
        acc_chk(1'b1, 40'hff_ffff_0000);
        rd_chk(DCRF_OFS_ACC1_X, 32'h0000_00ff, 1'b0);
        $display("test accumulator views done");
        core.wide_wr(1'b0, 41'h1ff_ffff_fffe);
        acc_chk(1'b0, 40'hff_ffff_fffe);
        chk(sat, 1'b0, "no saturation");
        core.wide_wr(1'b0, 41'h080_0000_0000);
        acc_chk(1'b0, DCRF_ACC_MAX);
        core.wide_wr(1'b1, 41'h17f_ffff_ffff);
        acc_chk(1'b1, DCRF_ACC_MIN);
        chk(sat, 1'b1, "saturation seen");
        rd_chk(DCRF_OFS_STAT, 32'h0000_0001, 1'b0);
        apb(1'b1, DCRF_OFS_STAT, 32'h0000_0001);
        rd_chk(DCRF_OFS_STAT, 32'h0000_0000, 1'b0);
        $display("test saturation done");
        apb(1'b1, 12'h058, 32'h0000_1000);
        core.push_one();
        core.push_one();
        rd_chk(12'h058, 32'h0000_1000 - 2 * DCRF_PUSH_STEP, 1'b0);
        rd_chk(12'h05c, 32'ha5c3_e05c, 1'b0);
        $display("test stack push done");
        stop_test();
    end

    // Watchdog well beyond the few hundred cycles the tests need
    initial begin
        #200us;
        err_count++;
        $display("ERROR %0t watchdog expired", $time);
        stop_test();
    end
endmodule
`default_nettype wire
